/* src/pisad_pkg.sv */
package pisad_pkg;

    // Decoded spaces that the block can select
    typedef enum logic [2:0] {
        PISAD_SP_NONE,
        PISAD_SP_LOCAL,
        PISAD_SP_IO,
        PISAD_SP_ID,
        PISAD_SP_INT,
        PISAD_SP_MEM
    } pisad_space_t;

    // Host side request as seen behind the bridge
    typedef struct packed {
        logic valid;
        logic mem_space;
        logic [2:0] bar;
        logic write;
        logic [31:0] offset;
        logic [15:0] wdata;
    } pisad_req_t;

    // Decode result
    typedef struct packed {
        logic hit;
        pisad_space_t space;
        logic [1:0] slot;
        logic [22:0] ip_addr;
    } pisad_dec_t;

    localparam logic [2:0] PISAD_BAR_IP = 3'h2;
    localparam int PISAD_SLOTS = 4;

    // Local control range
    localparam logic [31:0] PISAD_LOC_LO = 32'h0000_0500;
    localparam logic [31:0] PISAD_LOC_HI = 32'h0000_07FF;

    // Slot register area: slot base 0x1000 * (n+1), regions 0x100 apart
    localparam logic [31:0] PISAD_SLOT_BASE = 32'h0000_1000;
    localparam logic [31:0] PISAD_SLOT_STEP = 32'h0000_1000;
    localparam logic [31:0] PISAD_IO_OFS = 32'h0000_0000;
    localparam logic [31:0] PISAD_ID_OFS = 32'h0000_0100;
    localparam logic [31:0] PISAD_INT_OFS = 32'h0000_0200;
    localparam logic [31:0] PISAD_REG_SPAN = 32'h0000_0100;

    // Standard map memory windows, 8 MB each
    localparam logic [31:0] PISAD_MEM_STD_BASE = 32'h0100_0000;
    localparam logic [31:0] PISAD_MEM_STD_SIZE = 32'h0080_0000;
    localparam logic [31:0] PISAD_STD_SPAN = 32'h0400_0000;

    // Reduced map memory windows, 2 KB each
    localparam logic [31:0] PISAD_MEM_RED_BASE = 32'h0000_5000;
    localparam logic [31:0] PISAD_MEM_RED_SIZE = 32'h0000_0800;
    localparam logic [31:0] PISAD_RED_SPAN = 32'h0000_8000;

    // Slot clock rates and the bus timer
    localparam int PISAD_CLK_MHZ = 100;
    localparam int PISAD_IPCLK_SLOW_MHZ = 8;
    localparam int PISAD_IPCLK_FAST_MHZ = 32;
    localparam int PISAD_TIMEOUT_NS = 3200;
    localparam int PISAD_TIMEOUT_CYC =
        (PISAD_TIMEOUT_NS * PISAD_CLK_MHZ) / 1000;
    localparam int PISAD_TMR_W = 9;
    localparam logic [PISAD_TMR_W-1:0] PISAD_TMR_LAST =
        PISAD_TMR_W'(PISAD_TIMEOUT_CYC - 1);

    // Clock divider half periods in system cycles less one, rounded up so that
    // a slot never runs faster than the rate it asked for
    localparam logic [3:0] PISAD_HALF_SLOW =
        4'((PISAD_CLK_MHZ + 2 * PISAD_IPCLK_SLOW_MHZ - 1) /
           (2 * PISAD_IPCLK_SLOW_MHZ) - 1);
    localparam logic [3:0] PISAD_HALF_FAST =
        4'((PISAD_CLK_MHZ + 2 * PISAD_IPCLK_FAST_MHZ - 1) /
           (2 * PISAD_IPCLK_FAST_MHZ) - 1);

endpackage : pisad_pkg

/* src/pisad_clkdiv.sv */
`timescale 1ns/1ps
// Per-slot IP bus clock, 8 or 32 MHz picked by a level
module pisad_clkdiv (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic fast_in,
    output logic ipclk_out
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic clk_reg;
    logic clk_next;

    // Toggle at each half period; rate change applies to the half already running
    always_comb
    begin
        cnt_next = cnt_reg + 4'h1;
        clk_next = clk_reg;
        if (cnt_reg >= (fast_in ? pisad_pkg::PISAD_HALF_FAST
                                : pisad_pkg::PISAD_HALF_SLOW))
        begin
            cnt_next = 4'h0;
            clk_next = ~clk_reg;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cnt_reg <= 4'h0;
            clk_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            clk_reg <= clk_next;
        end
    end

    assign ipclk_out = clk_reg;
endmodule : pisad_clkdiv

/* src/pisad_decoder.sv */
// What the document requires of this block, its modules and the host
// R1 - Claim only memory-space accesses; host I/O space is never decoded
// R2 - Standard map gives each slot 8 MB memory; whole map spans 64 MB
// R3 - Reduced map gives each slot only a 2 KB memory window
// R4 - Map choice comes from the configuration store strap, not a register
// R5 - Lowest 16 KB decodes the same way in both maps
// R6 - Local control registers decode at 0x500 to 0x7FF in both maps
// R7 - Slots at 0x1000..0x4000; I/O +0, ID +0x100, INT +0x200, 256 bytes
// R8 - Standard memory windows start at 0x0100_0000 in 8 MB steps
// R9 - Reduced memory windows start at 0x5000 in 2 KB steps
// R10 - Window sizing readback returns zeros in every decoded address bit
// R11 - Slots and local registers reached only through the third window
// R12 - Slot I/O region spans 128 words, 256 bytes
// R13 - Unanswered access with timer on completes locally and interrupts; code pulses TIMEOUT_OUT but raises no host interrupt
// R14 - Module supplies an ID PROM within a 128-word ID space
// R15 - Module gives at least 12 ID bytes in low bytes of first words
// R16 - ID PROM holds signature, maker, model, revision, reserved zero
// R17 - ID PROM holds driver ID, byte count, CRC, then pack data
// R18 - Host tolerates both byte and 16-bit word ID layouts
// R19 - Each slot clock is selectable between 8 and 32 MHz by software
// R20 - All slot interrupts drive one host line; status tells which slot
// R21 - Reading INT region runs an interrupt acknowledge cycle
// R22 - Timer replies after 3.2 us, only for valid slot addresses
// R23 - Unlisted offsets start no IP cycle and select no slot
// R24 - One slot select and one space strobe, with in-region offset
`timescale 1ns/1ps
module pisad_decoder (
    input wire logic SYS_CLK_IN,
    input wire logic RESET_IN,
    input wire logic REDUCED_MAP_IN,
    input wire pisad_pkg::pisad_req_t REQ_IN,
    input wire logic IP_ACK_IN,
    input wire logic [15:0] IP_RDATA_IN,
    input wire logic [3:0] CLK_FAST_IN,
    input wire logic TIMER_EN_IN,
    input wire logic [7:0] IP_IRQ_IN,
    output logic [31:0] SIZE_MASK_OUT,
    output logic DONE_OUT,
    output logic [15:0] RDATA_OUT,
    output logic TIMEOUT_OUT,
    output logic LOCAL_SEL_OUT,
    output logic [3:0] SLOT_SEL_OUT,
    output logic IO_SEL_OUT,
    output logic ID_SEL_OUT,
    output logic INT_SEL_OUT,
    output logic MEM_SEL_OUT,
    output logic IP_WRITE_OUT,
    output logic [22:0] IP_ADDR_OUT,
    output logic [15:0] IP_WDATA_OUT,
    output logic [3:0] IP_CLK_OUT,
    output logic HOST_IRQ_OUT,
    output logic [3:0] IRQ_SLOT_OUT
);
    typedef enum logic [1:0] {ST_IDLE, ST_CYCLE, ST_DONE} pisad_st_t;

    // Address decode for the request path; sizing uses the span constants
    function automatic pisad_pkg::pisad_dec_t decode(
        input logic [31:0] ofs, input logic reduced);
        pisad_pkg::pisad_dec_t d;
        logic [31:0] rel;
        logic [31:0] mbase;
        logic [31:0] msize;
        d = '0;
        mbase = reduced ? pisad_pkg::PISAD_MEM_RED_BASE
                        : pisad_pkg::PISAD_MEM_STD_BASE; // R2 R3 R4
        msize = reduced ? pisad_pkg::PISAD_MEM_RED_SIZE
                        : pisad_pkg::PISAD_MEM_STD_SIZE; // R2 R3
        if (ofs >= pisad_pkg::PISAD_LOC_LO &&
            ofs <= pisad_pkg::PISAD_LOC_HI)
        begin
            d.hit = 1'b1;
            d.space = pisad_pkg::PISAD_SP_LOCAL; // R6 R5
        end
        for (int s = 0; s < pisad_pkg::PISAD_SLOTS; s++)
        begin
            rel = ofs - (pisad_pkg::PISAD_SLOT_BASE +
                         32'(s) * pisad_pkg::PISAD_SLOT_STEP); // R7 R5
            if (ofs >= pisad_pkg::PISAD_SLOT_BASE +
                       32'(s) * pisad_pkg::PISAD_SLOT_STEP &&
                rel < pisad_pkg::PISAD_INT_OFS + pisad_pkg::PISAD_REG_SPAN)
            begin
                d.hit = 1'b1;
                d.slot = 2'(s);
                d.ip_addr = 23'(rel[7:0]); // R12
                if (rel < pisad_pkg::PISAD_ID_OFS)
                    d.space = pisad_pkg::PISAD_SP_IO; // R12
                else if (rel < pisad_pkg::PISAD_INT_OFS)
                    d.space = pisad_pkg::PISAD_SP_ID;
                else
                    d.space = pisad_pkg::PISAD_SP_INT;
            end
            rel = ofs - (mbase + 32'(s) * msize);
            if (ofs >= mbase + 32'(s) * msize && rel < msize) // R8 R9
            begin
                d.hit = 1'b1;
                d.slot = 2'(s);
                d.space = pisad_pkg::PISAD_SP_MEM;
                d.ip_addr = rel[22:0]; // R24
            end
        end
        return d;
    endfunction : decode

    pisad_st_t st_reg, st_next;
    logic [pisad_pkg::PISAD_TMR_W-1:0] tmr_reg, tmr_next;
    logic done_reg, done_next;
    logic [15:0] rdata_reg, rdata_next;
    logic tout_reg, tout_next;
    logic loc_reg, loc_next;
    logic [3:0] slot_reg, slot_next;
    logic io_reg, io_next, id_reg, id_next;
    logic int_reg, int_next, mem_reg, mem_next;
    logic wr_reg, wr_next;
    logic [22:0] addr_reg, addr_next;
    logic [15:0] wdata_reg, wdata_next;
    logic [31:0] size_reg;
    logic irq_reg;
    logic [3:0] irqs_reg;
    logic [3:0] ipclk;
    pisad_pkg::pisad_dec_t dec;
    logic claim;

    assign dec = decode(REQ_IN.offset, REDUCED_MAP_IN);
    // Only memory space through the third window is claimed
    assign claim = REQ_IN.valid && REQ_IN.mem_space && // R1
                   REQ_IN.bar == pisad_pkg::PISAD_BAR_IP; // R11

    // Request sequencing: decode, run IP cycle, wait ack or timeout
    always_comb
    begin
        st_next = st_reg;
        tmr_next = tmr_reg;
        done_next = 1'b0;
        rdata_next = rdata_reg;
        tout_next = 1'b0;
        loc_next = loc_reg;
        slot_next = slot_reg;
        io_next = io_reg;
        id_next = id_reg;
        int_next = int_reg;
        mem_next = mem_reg;
        wr_next = wr_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        case (st_reg)
            ST_IDLE:
            begin
                if (claim)
                begin
                    wr_next = REQ_IN.write;
                    wdata_next = REQ_IN.wdata;
                    addr_next = dec.ip_addr;
                    tmr_next = '0;
                    if (dec.hit && dec.space != pisad_pkg::PISAD_SP_LOCAL)
                    begin
                        // Exactly one slot and one space per access
                        slot_next = 4'h1 << dec.slot; // R24
                        io_next = dec.space == pisad_pkg::PISAD_SP_IO;
                        id_next = dec.space == pisad_pkg::PISAD_SP_ID;
                        // Read here is an interrupt acknowledge cycle
                        int_next = dec.space == pisad_pkg::PISAD_SP_INT; // R21
                        mem_next = dec.space == pisad_pkg::PISAD_SP_MEM;
                        st_next = ST_CYCLE;
                    end
                    else
                    begin
                        // Local range handed off; misses just complete
                        loc_next = dec.hit; // R6
                        rdata_next = 16'h0000;
                        done_next = 1'b1; // R23
                        st_next = ST_DONE;
                    end
                end
            end
            ST_CYCLE:
            begin
                tmr_next = tmr_reg + 1'b1;
                if (IP_ACK_IN)
                begin
                    rdata_next = IP_RDATA_IN; // R21
                    done_next = 1'b1;
                    st_next = ST_DONE;
                end
                else if (TIMER_EN_IN && tmr_reg == pisad_pkg::PISAD_TMR_LAST)
                begin
                    // Timer makes the reply for a silent module
                    rdata_next = 16'hFFFF;
                    done_next = 1'b1; // R22 R13
                    tout_next = 1'b1; // R13
                    st_next = ST_DONE;
                end
                else if (tmr_reg == pisad_pkg::PISAD_TMR_LAST)
                    tmr_next = tmr_reg; // Hang as real bus would
                if (st_next == ST_DONE)
                begin
                    slot_next = 4'h0;
                    io_next = 1'b0;
                    id_next = 1'b0;
                    int_next = 1'b0;
                    mem_next = 1'b0;
                end
            end
            ST_DONE:
            begin
                // One idle cycle so the host drops its request
                loc_next = 1'b0;
                st_next = ST_IDLE;
            end
            default:
                st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RESET_IN)
        begin
            st_reg <= ST_IDLE;
            tmr_reg <= '0;
            done_reg <= 1'b0;
            rdata_reg <= 16'h0000;
            tout_reg <= 1'b0;
            loc_reg <= 1'b0;
            slot_reg <= 4'h0;
            io_reg <= 1'b0;
            id_reg <= 1'b0;
            int_reg <= 1'b0;
            mem_reg <= 1'b0;
            wr_reg <= 1'b0;
            addr_reg <= '0;
            wdata_reg <= 16'h0000;
        end
        else
        begin
            st_reg <= st_next;
            tmr_reg <= tmr_next;
            done_reg <= done_next;
            rdata_reg <= rdata_next;
            tout_reg <= tout_next;
            loc_reg <= loc_next;
            slot_reg <= slot_next;
            io_reg <= io_next;
            id_reg <= id_next;
            int_reg <= int_next;
            mem_reg <= mem_next;
            wr_reg <= wr_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
        end
    end

    // Sizing mask, interrupt merge; strap sampled every clock
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RESET_IN)
        begin
            size_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
            irqs_reg <= 4'h0;
        end
        else
        begin
            size_reg <= ~((REDUCED_MAP_IN ? pisad_pkg::PISAD_RED_SPAN
                          : pisad_pkg::PISAD_STD_SPAN) - 32'h1); // R10 R4
            irq_reg <= |IP_IRQ_IN; // R20
            for (int s = 0; s < pisad_pkg::PISAD_SLOTS; s++)
                irqs_reg[s] <= |IP_IRQ_IN[2*s +: 2]; // R20
        end
    end

    // Slot clocks, each rate set by its own control level
    for (genvar g = 0; g < pisad_pkg::PISAD_SLOTS; g++)
    begin : g_clk
        pisad_clkdiv u_div (
            .clk_in(SYS_CLK_IN),
            .rst_in(RESET_IN),
            .fast_in(CLK_FAST_IN[g]), // R19
            .ipclk_out(ipclk[g])
        );
    end

    assign SIZE_MASK_OUT = size_reg;
    assign DONE_OUT = done_reg;
    assign RDATA_OUT = rdata_reg;
    assign TIMEOUT_OUT = tout_reg;
    assign LOCAL_SEL_OUT = loc_reg;
    assign SLOT_SEL_OUT = slot_reg;
    assign IO_SEL_OUT = io_reg;
    assign ID_SEL_OUT = id_reg;
    assign INT_SEL_OUT = int_reg;
    assign MEM_SEL_OUT = mem_reg;
    assign IP_WRITE_OUT = wr_reg;
    assign IP_ADDR_OUT = addr_reg;
    assign IP_WDATA_OUT = wdata_reg;
    assign IP_CLK_OUT = ipclk;
    assign HOST_IRQ_OUT = irq_reg;
    assign IRQ_SLOT_OUT = irqs_reg;
endmodule : pisad_decoder

/* test/pisad_monitor.sv */
`timescale 1ns/1ps
// Watches decode and reply outputs against request, strap and module
module pisad_monitor (
    input wire logic SYS_CLK_IN,
    input wire logic RESET_IN,
    input wire logic REDUCED_MAP_IN,
    input wire pisad_pkg::pisad_req_t REQ_IN,
    input wire logic IP_ACK_IN,
    input wire logic [15:0] IP_RDATA_IN,
    input wire logic TIMER_EN_IN,
    input wire logic [7:0] IP_IRQ_IN,
    input wire logic [31:0] SIZE_MASK_OUT,
    input wire logic DONE_OUT,
    input wire logic [15:0] RDATA_OUT,
    input wire logic TIMEOUT_OUT,
    input wire logic [3:0] SLOT_SEL_OUT,
    input wire logic IO_SEL_OUT,
    input wire logic ID_SEL_OUT,
    input wire logic INT_SEL_OUT,
    input wire logic MEM_SEL_OUT,
    input wire logic IP_WRITE_OUT,
    input wire logic [22:0] IP_ADDR_OUT,
    input wire logic HOST_IRQ_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RESET_IN);
    // Space strobes as one vector
    wire logic [3:0] sp = {IO_SEL_OUT, ID_SEL_OUT, INT_SEL_OUT, MEM_SEL_OUT};
    // Slot cycle opened while the timer guards it
    sequence s_guarded;
        $rose(|SLOT_SEL_OUT) && TIMER_EN_IN;
    endsequence
    // Module answers a read
    sequence s_answer;
        IP_ACK_IN && (|SLOT_SEL_OUT) && !IP_WRITE_OUT;
    endsequence
    one_hot_a: assert property (((|sp) || (|SLOT_SEL_OUT)) |->
        $onehot(SLOT_SEL_OUT) && $onehot(sp))
        else $error("select not one-hot");
    reg_addr_a: assert property ((|sp[3:1]) |->
        IP_ADDR_OUT[22:8] == 15'h0000) else $error("register offset wide");
    red_addr_a: assert property (MEM_SEL_OUT && REDUCED_MAP_IN |->
        IP_ADDR_OUT[22:11] == 12'h000) else $error("reduced offset wide");
    tmo_data_a: assert property (TIMEOUT_OUT |->
        DONE_OUT && RDATA_OUT == 16'hFFFF) else $error("bad timer reply");
    tmo_bound_a: assert property (s_guarded |-> ##[1:321] DONE_OUT)
        else $error("guarded cycle never ended");
    ack_reply_a: assert property (s_answer |=> DONE_OUT &&
        !TIMEOUT_OUT && RDATA_OUT == $past(IP_RDATA_IN))
        else $error("answer not passed on");
    refuse_a: assert property (REQ_IN.valid && !DONE_OUT &&
        !(REQ_IN.mem_space && REQ_IN.bar == pisad_pkg::PISAD_BAR_IP)
        && SLOT_SEL_OUT == 4'h0 |=> !DONE_OUT && SLOT_SEL_OUT == 4'h0)
        else $error("refused request served");
    size_mask_a: assert property (!$past(RESET_IN) |->
        SIZE_MASK_OUT == ($past(REDUCED_MAP_IN) ? 32'hFFFF_8000
        : 32'hFC00_0000)) else $error("sizing mask wrong");
    irq_merge_a: assert property (!$past(RESET_IN) |->
        HOST_IRQ_OUT == |$past(IP_IRQ_IN)) else $error("host irq wrong");
endmodule : pisad_monitor

/* test/pisad_ipmod.sv */
`timescale 1ns/1ps
// Four behavioural modules sharing one logic bus
module pisad_ipmod (
    input wire logic clk_in,
    input wire logic [3:0] slot_sel_in,
    input wire logic id_sel_in,
    input wire logic int_sel_in,
    input wire logic [22:0] addr_in,
    input wire logic [3:0] present_in,
    input wire logic [3:0] wait_in,
    output logic ack_out,
    output logic [15:0] rdata_out
);
    // Maker code, arbitrary value
    localparam logic [7:0] MAKER = 8'h5A;
    logic [4:0] cnt_reg = 5'h00;
    logic [15:0] last_reg = 16'h0000;
    logic [7:0] id_byte;
    logic [15:0] word;
    wire logic [1:0] slot = {|slot_sel_in[3:2],
        slot_sel_in[3] | slot_sel_in[1]};
    wire logic live = |(slot_sel_in & present_in);
    // Byte layout ID contents, low byte of each word
    always_comb
    begin
        case (addr_in[7:0])
            8'h08: id_byte = MAKER;
            8'h0E: id_byte = 8'h00;
            8'h14: id_byte = 8'h0C;
            default: id_byte = addr_in[7:0] ^ 8'h3C;
        endcase
        word = id_sel_in ? {8'h00, id_byte}
            : int_sel_in ? 16'h00C0 + 16'(slot)
            : {2'h0, slot, addr_in[11:0]};
    end
    // Absent slot never answers; released data lines show inverse
    assign ack_out = live && cnt_reg == {1'h0, wait_in};
    assign rdata_out = ack_out ? word : ~last_reg;
    // Count wait states while selected; one ack each cycle
    always_ff @(posedge clk_in)
    begin
        if (!live)
            cnt_reg <= 5'h00;
        else if (cnt_reg <= {1'h0, wait_in})
            cnt_reg <= cnt_reg + 5'h01;
        if (ack_out)
            last_reg <= word;
    end
endmodule : pisad_ipmod

/* test/pisad_decoder_bench.sv */
`timescale 1ns/1ps
module pisad_decoder_bench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic red = 1'h0;
    logic ten = 1'h0;
    logic [3:0] fast = 4'h0;
    logic [7:0] irq = 8'h00;
    logic [3:0] present = 4'hF;
    logic [3:0] wait_c = 4'h1;
    pisad_pkg::pisad_req_t req = '0;
    logic ack, done, tmo, loc, io, id, intr, mem, ipw, hirq, to_seen;
    logic [15:0] ip_rd, rd, ipwd, rd_seen;
    logic [31:0] smask;
    logic [3:0] ssel, ipclk, islot;
    logic [22:0] ipa;
    logic [8:0] sel_seen;
    logic [39:0] cap;
    int lat;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // System clock, 100 MHz
    always #5 clk = ~clk;
    pisad_decoder DUT (.SYS_CLK_IN(clk), .RESET_IN(rst),
        .REDUCED_MAP_IN(red), .REQ_IN(req), .IP_ACK_IN(ack),
        .IP_RDATA_IN(ip_rd), .CLK_FAST_IN(fast), .TIMER_EN_IN(ten),
        .IP_IRQ_IN(irq), .SIZE_MASK_OUT(smask), .DONE_OUT(done),
        .RDATA_OUT(rd), .TIMEOUT_OUT(tmo), .LOCAL_SEL_OUT(loc),
        .SLOT_SEL_OUT(ssel), .IO_SEL_OUT(io), .ID_SEL_OUT(id),
        .INT_SEL_OUT(intr), .MEM_SEL_OUT(mem), .IP_WRITE_OUT(ipw),
        .IP_ADDR_OUT(ipa), .IP_WDATA_OUT(ipwd), .IP_CLK_OUT(ipclk),
        .HOST_IRQ_OUT(hirq), .IRQ_SLOT_OUT(islot));
    pisad_ipmod IPM (.clk_in(clk), .slot_sel_in(ssel), .id_sel_in(id),
        .int_sel_in(intr), .addr_in(ipa), .present_in(present),
        .wait_in(wait_c), .ack_out(ack), .rdata_out(ip_rd));
    // Hang guard, well above the longest expected run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic check(input string what, input logic [39:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : check
    // One host access held until done; valid dropped after it
    task automatic access(input logic [31:0] ofs, input logic wr);
        @(negedge clk);
        req = '{1'h1, 1'h1, pisad_pkg::PISAD_BAR_IP, wr, ofs, 16'hC3A5};
        sel_seen = 9'h000;
        lat = 0;
        do
        begin
            @(posedge clk);
            #1;
            lat++;
            if (sel_seen == 9'h000)
                sel_seen = {loc, ssel, io, id, intr, mem};
            if (|ssel)
                cap = {ipw, ipwd, ipa};
        end while (done !== 1'h1 && lat < 400);
        rd_seen = rd;
        to_seen = tmo;
        check("done", 1, done);
        @(negedge clk);
        req.valid = 1'h0;
    endtask : access
    task automatic decode(input logic [31:0] a, input logic [8:0] s,
        input logic [22:0] x);
        access(a, 1'h0);
        check("select", s, sel_seen);
        if (|s[7:4])
            check("ip addr", x, cap[22:0]);
    endtask : decode
    task automatic t_regions();
        for (int m = 0; m < 2; m++)
            for (int s = 0; s < 4; s++)
                for (int r = 0; r < 3; r++)
                begin
                    red = m[0];
                    decode(32'h0000_1000 * (s + 1) + 32'h0000_0100 * r
                        + 32'h0000_00FE, {1'h0, 4'h1 << s, 4'h8 >> r},
                        23'h0000FE);
                    if (r == 2)
                        check("vector", 16'h00C0 + 16'(s), rd_seen);
                end
        access(32'h0000_1108, 1'h0);
        check("id byte", 16'h005A, rd_seen);
        access(32'h0000_3010, 1'h1);
        check("write", {1'h1, 16'hC3A5, 23'h000010}, cap);
        $display("t_regions finished");
    endtask : t_regions
    task automatic t_mem();
        red = 1'h0;
        repeat (2) @(negedge clk);
        check("std mask", 32'hFC00_0000, smask);
        decode(32'h0100_0000, 9'h011, 23'h000000);
        decode(32'h017F_FFFE, 9'h011, 23'h7FFFFE);
        decode(32'h0180_0000, 9'h021, 23'h000000);
        decode(32'h0200_0002, 9'h041, 23'h000002);
        decode(32'h02FF_FFFE, 9'h081, 23'h7FFFFE);
        decode(32'h0300_0000, 9'h000, 23'h000000);
        decode(32'h0000_5000, 9'h000, 23'h000000);
        red = 1'h1;
        repeat (2) @(negedge clk);
        check("red mask", 32'hFFFF_8000, smask);
        decode(32'h0000_5000, 9'h011, 23'h000000);
        decode(32'h0000_57FE, 9'h011, 23'h0007FE);
        decode(32'h0000_5800, 9'h021, 23'h000000);
        decode(32'h0000_6000, 9'h041, 23'h000000);
        decode(32'h0000_6FFE, 9'h081, 23'h0007FE);
        decode(32'h0000_7000, 9'h000, 23'h000000);
        decode(32'h0100_0000, 9'h000, 23'h000000);
        red = 1'h0;
        $display("t_mem finished");
    endtask : t_mem
    task automatic t_local();
        decode(32'h0000_0500, 9'h100, 23'h000000);
        check("local wait", 1, lat);
        check("local data", 16'h0000, rd_seen);
        decode(32'h0000_07FE, 9'h100, 23'h000000);
        decode(32'h0000_04FE, 9'h000, 23'h000000);
        decode(32'h0000_0800, 9'h000, 23'h000000);
        decode(32'h0000_1300, 9'h000, 23'h000000);
        $display("t_local finished");
    endtask : t_local
    task automatic t_refuse();
        logic hit;
        for (int k = 0; k < 3; k++)
        begin
            @(negedge clk);
            req = '{1'h1, k != 0, 3'(k == 0 ? 2 : k - 1), 1'h0,
                32'h0000_1000, 16'h0000};
            hit = 1'h0;
            repeat (30) @(posedge clk) #1 hit = hit | done | (|ssel);
            check("refused", 0, hit);
            @(negedge clk);
            req.valid = 1'h0;
        end
        $display("t_refuse finished");
    endtask : t_refuse
    task automatic t_timer();
        ten = 1'h1;
        present = 4'h7;
        access(32'h0000_4000, 1'h0);
        check("timeout", 1, to_seen);
        check("fill", 16'hFFFF, rd_seen);
        check("wait", 1 + pisad_pkg::PISAD_TIMEOUT_CYC, lat);
        wait_c = 4'hF;
        access(32'h0100_0000, 1'h0);
        check("slow ack", 0, to_seen);
        access(32'h0000_0900, 1'h0);
        check("miss wait", 1, lat);
        wait_c = 4'h1;
        ten = 1'h0;
        $display("t_timer finished");
    endtask : t_timer
    task automatic rise(input int s, output int n);
        logic p;
        n = 0;
        do
        begin
            p = ipclk[s];
            @(posedge clk);
            #1;
            n++;
        end while (!(ipclk[s] && !p) && n < 100);
    endtask : rise
    task automatic t_clk();
        int n;
        fast = 4'h5;
        repeat (30) @(negedge clk);
        for (int s = 0; s < 4; s++)
        begin
            rise(s, n);
            rise(s, n);
            check("clock period", s % 2 ? 14 : 4, n);
        end
        $display("t_clk finished");
    endtask : t_clk
    task automatic t_irq();
        for (int b = 0; b < 8; b++)
        begin
            @(negedge clk);
            irq = 8'h01 << b;
            repeat (2) @(negedge clk);
            check("host irq", 1, hirq);
            check("irq slot", 4'h1 << (b / 2), islot);
            irq = 8'h00;
        end
        repeat (2) @(negedge clk);
        check("irq idle", 0, hirq);
        $display("t_irq finished");
    endtask : t_irq
    initial
    begin
        repeat (12) @(negedge clk);
        check("reset", 0, {smask, done, ssel});
        rst = 1'h0;
        t_regions();
        t_mem();
        t_local();
        t_refuse();
        t_timer();
        t_clk();
        t_irq();
        print_verdict();
    end
endmodule : pisad_decoder_bench
bind pisad_decoder pisad_monitor MON (.SYS_CLK_IN, .RESET_IN,
    .REDUCED_MAP_IN, .REQ_IN, .IP_ACK_IN, .IP_RDATA_IN, .TIMER_EN_IN,
    .IP_IRQ_IN, .SIZE_MASK_OUT, .DONE_OUT, .RDATA_OUT, .TIMEOUT_OUT,
    .SLOT_SEL_OUT, .IO_SEL_OUT, .ID_SEL_OUT, .INT_SEL_OUT, .MEM_SEL_OUT,
    .IP_WRITE_OUT, .IP_ADDR_OUT, .HOST_IRQ_OUT);
